// [sasx_map.svh]
// Constants for the power-down and file-subtract execution block
// Assumes inclusion by the design modules and the testbench
`ifndef SASX_MAP_SVH
`define SASX_MAP_SVH

// ----------------------------------------------------------------
// Opcode encodings
// ----------------------------------------------------------------
`define SASX_OP_SLEEP      14'h0063
`define SASX_SUB_MASK      14'h3F00
`define SASX_SUB_MATCH     14'h0200
`define SASX_DIR_BIT       7
`define SASX_ADDR_MSB      6
`define SASX_NIB_MSB       3

// ----------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------
`define SASX_REG_INSTR     8'h00
`define SASX_REG_WREG      8'h04
`define SASX_REG_STATUS    8'h08
`define SASX_REG_WAKE      8'h0C
`define SASX_REG_FILE      8'h80
`define SASX_FILE_DEPTH    128

// ----------------------------------------------------------------
// Status bit positions and reset values
// ----------------------------------------------------------------
`define SASX_ST_C          0
`define SASX_ST_DC         1
`define SASX_ST_Z          2
`define SASX_ST_PD         3
`define SASX_ST_TO         4
`define SASX_ST_SLEEP      5
`define SASX_RST_WREG      8'h00
`define SASX_RST_FILE      8'h00
`define SASX_RST_WDT       8'h00
`define SASX_RST_PRE       8'h00
`define SASX_RST_ZERO32    32'h0000_0000

`endif

// [sasx_pkg.sv]
// Types for the power-down and file-subtract execution block
// Assumes sasx_map.svh is on the include path
package sasx_pkg;

    typedef struct packed {
        logic to;
        logic pd;
        logic z;
        logic dc;
        logic c;
    } sasx_flags_t;

    typedef struct packed {
        logic [7:0] diff;
        logic       carry;
        logic       dcarry;
        logic       zero;
    } sasx_alu_t;

    typedef enum logic [1:0] {
        SASX_RUN   = 2'b00,
        SASX_EXEC  = 2'b01,
        SASX_SLEEP = 2'b10
    } sasx_state_t;

endpackage

// [sasx_sub.sv]
// Subtractor: file operand minus working register
// Assumes purely combinational use inside the core
`timescale 1ns/10ps
`include "sasx_map.svh"
module sasx_sub (
    input  wire logic [7:0]        f_val,
    input  wire logic [7:0]        w_val,
    output sasx_pkg::sasx_alu_t    res
);
    wire logic [8:0] full_sum;
    wire logic [4:0] nib_sum;

    // Two's complement: f + ~w + 1, carry means no borrow
    assign full_sum   = {1'b0, f_val} + {1'b0, ~w_val} + 9'h001;
    assign nib_sum    = {1'b0, f_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
    assign res.diff   = full_sum[7:0];
    assign res.carry  = full_sum[8];
    assign res.dcarry = nib_sum[4];
    assign res.zero   = (full_sum[7:0] == 8'h00);
endmodule

// [sasx_file.sv]
// File register array, 128 bytes of flip-flops
// Assumes one write port and two read ports
`timescale 1ns/10ps
`include "sasx_map.svh"
module sasx_file (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [6:0] raddr_a,
    output wire logic [7:0] rdata_a,
    input  wire logic [6:0] raddr_b,
    output wire logic [7:0] rdata_b
);
    logic [7:0] mem [0:`SASX_FILE_DEPTH-1];

    genvar i;
    generate
        for (i = 0; i < `SASX_FILE_DEPTH; i = i + 1) begin : g_ent
            always_ff @(posedge clk) begin
                if (rst)
                    mem[i] <= `SASX_RST_FILE;
                else if (we && waddr == 7'(i))
                    mem[i] <= wdata;
            end
        end
    endgenerate

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule

// [sasx_core.sv]
// Execution core for the power-down and file-subtract instructions
// Assumes an APB master feeds opcodes and reads state; one 25 MHz clock
`timescale 1ns/10ps
`include "sasx_map.svh"

//Contract
// [RULE_01] Decoding the power-down opcode clears the power-down flag.
// [RULE_02] The power-down instruction sets the time-out flag.
// [RULE_03] The power-down instruction clears the watchdog counter and its prescaler.
// [RULE_04] After power-down the core sleeps, stops its oscillator and fetches nothing.
// [RULE_05] File-subtract computes file register minus working register in two's complement.
// [RULE_06] With direction bit 0 the difference goes to the working register only.
// [RULE_07] With direction bit 1 the difference goes back into the file register.
// [RULE_08] A positive nonzero difference sets carry and clears zero.
// [RULE_09] A zero difference sets carry, zero and digit carry.
// [RULE_10] A borrow clears carry; one minus two gives FF with zero and digit carry clear.
// [RULE_11] Each instruction is one word and completes in one instruction cycle.
// [RULE_12] The file address is the low seven opcode bits, covering 0 to 127.
module sasx_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wdt_tick,
    output logic             osc_run,
    output logic             sleeping,
    output logic [7:0]       watchdog_counter
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sasx_pkg::sasx_state_t state;
    sasx_pkg::sasx_state_t next_state;
    sasx_pkg::sasx_flags_t flags;
    sasx_pkg::sasx_alu_t   alu;
    logic [7:0]            wreg;
    logic [7:0]            prescaler;
    logic [13:0]           instr;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire logic        acc       = psel && penable;
    wire logic        wr_acc    = acc && pwrite;
    wire logic        hit_instr = (paddr == `SASX_REG_INSTR);
    wire logic        hit_wreg  = (paddr == `SASX_REG_WREG);
    wire logic        hit_stat  = (paddr == `SASX_REG_STATUS);
    wire logic        hit_wake  = (paddr == `SASX_REG_WAKE);
    wire logic        hit_file  = paddr[7] && (paddr[1:0] == 2'b00);
    wire logic        mapped    = hit_instr | hit_wreg | hit_stat | hit_wake | hit_file;
    wire logic [6:0]  bus_faddr = paddr[6:0] >> 2;

    // Opcode written only while running; during sleep it is ignored
    wire logic        load_op   = wr_acc && hit_instr && (state == sasx_pkg::SASX_RUN);
    wire logic        wake_req  = wr_acc && hit_wake && pwdata[0];

    // ----------------------------------------------------------------
    // Decode of the held opcode
    // ----------------------------------------------------------------
    wire logic        exec      = (state == sasx_pkg::SASX_EXEC);               // [RULE_11]
    wire logic        is_sleep  = (instr == `SASX_OP_SLEEP);                   // [RULE_01]
    wire logic        is_sub    = ((instr & `SASX_SUB_MASK) == `SASX_SUB_MATCH); // [RULE_05]
    wire logic        dir_file  = instr[`SASX_DIR_BIT];
    wire logic [6:0]  op_faddr  = instr[`SASX_ADDR_MSB:0];                    // [RULE_12]
    wire logic        do_sleep  = exec && is_sleep;
    wire logic        do_sub    = exec && is_sub;

    // ----------------------------------------------------------------
    // File array and subtractor
    // ----------------------------------------------------------------
    wire logic [7:0]  f_operand;
    wire logic [7:0]  f_bus;
    wire logic        sub_to_file = do_sub && dir_file;                         // [RULE_07]
    wire logic        bus_to_file = wr_acc && hit_file && !exec;
    wire logic        file_we     = sub_to_file || bus_to_file;
    wire logic [6:0]  file_waddr  = sub_to_file ? op_faddr : bus_faddr;
    wire logic [7:0]  file_wdata  = sub_to_file ? alu.diff : pwdata[7:0];

    sasx_file u_file (
        .clk     (clk),
        .rst     (rst),
        .we      (file_we),
        .waddr   (file_waddr),
        .wdata   (file_wdata),
        .raddr_a (op_faddr),
        .rdata_a (f_operand),
        .raddr_b (bus_faddr),
        .rdata_b (f_bus)
    );

    sasx_sub u_sub (
        .f_val (f_operand),                                                     // [RULE_05]
        .w_val (wreg),
        .res   (alu)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            sasx_pkg::SASX_RUN: begin
                if (load_op)
                    next_state = sasx_pkg::SASX_EXEC;
            end
            sasx_pkg::SASX_EXEC: begin
                next_state = is_sleep ? sasx_pkg::SASX_SLEEP : sasx_pkg::SASX_RUN; // [RULE_04]
            end
            sasx_pkg::SASX_SLEEP: begin
                if (wake_req)
                    next_state = sasx_pkg::SASX_RUN;
            end
            default: begin
                next_state = sasx_pkg::SASX_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            state <= sasx_pkg::SASX_RUN;
        else
            state <= next_state;
    end

    always_ff @(posedge clk) begin
        if (rst)
            instr <= 14'h0000;
        else if (load_op)
            instr <= pwdata[13:0];
    end

    // ----------------------------------------------------------------
    // Sequencer checks
    // ----------------------------------------------------------------
    load_exec_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_11]
        load_op |=> (exec && instr == $past(pwdata[13:0])))
        else $error("opcode not taken for execution");
    run_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state == sasx_pkg::SASX_RUN && !load_op) |=> (state == sasx_pkg::SASX_RUN))
        else $error("left run state without an opcode");

    // ----------------------------------------------------------------
    // Working register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst)
            wreg <= `SASX_RST_WREG;
        else if (do_sub && !dir_file)
            wreg <= alu.diff;                                                   // [RULE_06]
        else if (wr_acc && hit_wreg && !exec)
            wreg <= pwdata[7:0];
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= '0;
        end else if (do_sleep) begin
            flags.pd <= 1'b0;                                                   // [RULE_01]
            flags.to <= 1'b1;                                                   // [RULE_02]
        end else if (do_sub) begin
            flags.c  <= alu.carry;                                              // [RULE_08] [RULE_10]
            flags.z  <= alu.zero;                                               // [RULE_09]
            flags.dc <= alu.dcarry;                                             // [RULE_09]
        end else if (wr_acc && hit_stat) begin
            flags <= pwdata[`SASX_ST_TO:0];
        end
    end

    // ----------------------------------------------------------------
    // Watchdog counter and prescaler
    // ----------------------------------------------------------------
    wire logic pre_wrap = (prescaler == 8'hFF);

    always_ff @(posedge clk) begin
        if (rst) begin
            prescaler        <= `SASX_RST_PRE;
            watchdog_counter <= `SASX_RST_WDT;
        end else if (do_sleep) begin
            prescaler        <= `SASX_RST_PRE;                                  // [RULE_03]
            watchdog_counter <= `SASX_RST_WDT;                                  // [RULE_03]
        end else if (wdt_tick) begin
            prescaler <= prescaler + 8'h01;
            if (pre_wrap)
                watchdog_counter <= watchdog_counter + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog checks
    // ----------------------------------------------------------------
    wdt_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!do_sleep && !wdt_tick) |=> ($stable(watchdog_counter) && $stable(prescaler)))
        else $error("watchdog moved without a tick");
    pre_step_a: assert property (@(posedge clk) disable iff (rst)
        (wdt_tick && !do_sleep) |=> (prescaler == $past(prescaler) + 8'h01))
        else $error("prescaler did not step");
    wdt_step_a: assert property (@(posedge clk) disable iff (rst)
        (wdt_tick && !do_sleep && pre_wrap)
            |=> (watchdog_counter == $past(watchdog_counter) + 8'h01))
        else $error("watchdog did not step on wrap");

    // ----------------------------------------------------------------
    // Oscillator and sleep outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_run  <= 1'b1;
            sleeping <= 1'b0;
        end else begin
            osc_run  <= (next_state != sasx_pkg::SASX_SLEEP);                   // [RULE_04]
            sleeping <= (next_state == sasx_pkg::SASX_SLEEP);                   // [RULE_04]
        end
    end

    // ----------------------------------------------------------------
    // Sleep checks
    // ----------------------------------------------------------------
    sleep_out_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_04]
        sleeping == (state == sasx_pkg::SASX_SLEEP))
        else $error("sleep output out of step");
    osc_sleep_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_04]
        osc_run != sleeping)
        else $error("oscillator runs in sleep");
    sleep_no_exec_a: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (state == sasx_pkg::SASX_SLEEP) |=> (state != sasx_pkg::SASX_EXEC))
        else $error("instruction executed in sleep");
    sleep_instr_a: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (state == sasx_pkg::SASX_SLEEP) |=> $stable(instr))
        else $error("opcode fetched in sleep");
    sleep_wait_a: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (state == sasx_pkg::SASX_SLEEP && !wake_req) |=> (state == sasx_pkg::SASX_SLEEP))
        else $error("left sleep without wake");
    wake_run_a: assert property (@(posedge clk) disable iff (rst)
        (state == sasx_pkg::SASX_SLEEP && wake_req) |=> (state == sasx_pkg::SASX_RUN && osc_run))
        else $error("wake did not resume");
    sleep_flags_a: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (state == sasx_pkg::SASX_SLEEP && !(wr_acc && hit_stat)) |=> $stable(flags))
        else $error("flags changed in sleep");

    // ----------------------------------------------------------------
    // APB read and answer, no wait states
    // ----------------------------------------------------------------
    wire logic [31:0] stat_word = {26'h0, (state == sasx_pkg::SASX_SLEEP), flags};
    wire logic [31:0] rd_mux    = hit_instr ? {18'h0, instr} :
                                  hit_wreg  ? {24'h0, wreg} :
                                  hit_stat  ? stat_word :
                                  hit_file  ? {24'h0, f_bus} :
                                  hit_wake  ? `SASX_RST_ZERO32 : `SASX_RST_ZERO32;
    wire logic        bad_wr    = pwrite && hit_instr && (state != sasx_pkg::SASX_RUN);

    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `SASX_RST_ZERO32;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (!mapped || bad_wr);
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : `SASX_RST_ZERO32;
        end
    end

    // ----------------------------------------------------------------
    // Bus checks
    // ----------------------------------------------------------------
    ready_next_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable) |=> pready)
        else $error("no ready after setup");
    err_ready_a: assert property (@(posedge clk) disable iff (rst)
        pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
        !pready |-> (prdata == `SASX_RST_ZERO32))
        else $error("read data outside answer");
    unmapped_err_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && !mapped) |=> pslverr)
        else $error("unmapped access not refused");
    instr_refuse_a: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (psel && !penable && pwrite && hit_instr && state != sasx_pkg::SASX_RUN)
            |=> pslverr)
        else $error("opcode write not refused");
    rd_wreg_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && !pwrite && hit_wreg) |=> (prdata[7:0] == $past(wreg)))
        else $error("working register read wrong");
    rd_file_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && !pwrite && hit_file) |=> (prdata[7:0] == $past(f_bus)))
        else $error("file register read wrong");

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sleep_pd_a: assert property (@(posedge clk) disable iff (rst)   // [RULE_01]
        do_sleep |=> !flags.pd) else $error("power-down flag not cleared");
    sleep_to_a: assert property (@(posedge clk) disable iff (rst)   // [RULE_02]
        do_sleep |=> flags.to) else $error("time-out flag not set");
    sleep_wdt_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_03]
        do_sleep |=> (watchdog_counter == 8'h00 && prescaler == 8'h00))
        else $error("watchdog not cleared");
    sleep_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        do_sleep |=> (sleeping && !osc_run && state == sasx_pkg::SASX_SLEEP))
        else $error("sleep state not held");
    sub_wreg_a: assert property (@(posedge clk) disable iff (rst)   // [RULE_06]
        (do_sub && !dir_file) |=> (wreg == ($past(f_operand) - $past(wreg))))
        else $error("working register difference wrong");
    sub_file_a: assert property (@(posedge clk) disable iff (rst)   // [RULE_07]
        (do_sub && dir_file) |=> ($stable(wreg) && f_operand == $past(alu.diff)))
        else $error("file register difference wrong");
    sub_pos_a: assert property (@(posedge clk) disable iff (rst)    // [RULE_08]
        (do_sub && f_operand > wreg) |=> (flags.c && !flags.z))
        else $error("positive result flags wrong");
    sub_zero_a: assert property (@(posedge clk) disable iff (rst)   // [RULE_09]
        (do_sub && f_operand == wreg) |=> (flags.c && flags.z && flags.dc))
        else $error("zero result flags wrong");
    sub_neg_a: assert property (@(posedge clk) disable iff (rst)    // [RULE_10]
        (do_sub && f_operand < wreg) |=> (!flags.c && !flags.z))
        else $error("borrow flags wrong");
    one_cycle_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_11]
        exec |=> (state != sasx_pkg::SASX_EXEC))
        else $error("instruction took more than one cycle");
    wr_wreg_a: assert property (@(posedge clk) disable iff (rst)
        (wr_acc && hit_wreg && !exec) |=> (wreg == $past(pwdata[7:0])))
        else $error("working register write lost");
    exec_whold_a: assert property (@(posedge clk) disable iff (rst)
        (exec && !is_sub) |=> $stable(wreg))
        else $error("working register changed without subtract");
    stat_wr_a: assert property (@(posedge clk) disable iff (rst)
        (wr_acc && hit_stat && !exec) |=> (flags == $past(pwdata[`SASX_ST_TO:0])))
        else $error("status write lost");
    sub_diff_a: assert property (@(posedge clk) disable iff (rst)   // [RULE_05]
        do_sub |-> (8'(alu.diff + wreg) == f_operand))
        else $error("difference plus working register wrong");
    sub_carry_a: assert property (@(posedge clk) disable iff (rst)  // [RULE_10]
        do_sub |=> (flags.c == ($past(f_operand) >= $past(wreg))))
        else $error("carry flag wrong");
    sub_dc_a: assert property (@(posedge clk) disable iff (rst)     // [RULE_09]
        do_sub |=> (flags.dc == ($past(f_operand[3:0]) >= $past(wreg[3:0]))))
        else $error("digit carry flag wrong");
endmodule

// [sleep_and_subtract_exec_tb.sv]
// Testbench for the power-down and file-subtract execution core
// Assumes sasx_map.svh on the include path and the design files compiled first
`timescale 1ns/10ps
`include "sasx_map.svh"
module sleep_and_subtract_exec_tb;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wdt_tick;
    logic        osc_run;
    logic        sleeping;
    logic [7:0]  watchdog_counter;
    logic [31:0] rd;
    logic        err;
    logic [1:0]  exp_pdto;
    int          errors;
    int          n_tests;
    int          cycles;

    sasx_core DUT (
        .clk              (clk),
        .rst              (rst),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .wdt_tick         (wdt_tick),
        .osc_run          (osc_run),
        .sleeping         (sleeping),
        .watchdog_counter (watchdog_counter)
    );

    // ----------------------------------------------------------------
    // Clock, timeout and report
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic results();
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // APB transfer and watchdog tick drivers
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        @(posedge clk);
        wdt_tick <= 1'b1;
        repeat (n) @(posedge clk);
        wdt_tick <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // One file-subtract case with readback of W, file and status
    // ----------------------------------------------------------------
    task automatic sub_case(input logic [7:0] f, input logic [7:0] w, input logic d,
                            input logic [4:0] n);
        logic [7:0]  diff;
        logic [31:0] st;
        logic [7:0]  fa;
        diff = f - w;
        st   = {27'h0, exp_pdto, diff == 8'h00, f[3:0] >= w[3:0], f >= w};
        fa   = `SASX_REG_FILE + {1'b0, n, 2'b00};
        apb(1'b1, `SASX_REG_WREG, {24'h0, w});
        apb(1'b1, fa, {24'h0, f});
        apb(1'b1, `SASX_REG_INSTR, {18'h0, `SASX_SUB_MATCH | {6'h0, d, 2'b00, n}});
        chk({31'h0, err}, 32'h0, "instr accepted");
        apb(1'b0, `SASX_REG_WREG, 32'h0);
        chk(rd, {24'h0, d ? w : diff}, "w after sub");
        apb(1'b0, fa, 32'h0);
        chk(rd, {24'h0, d ? diff : f}, "file after sub");
        apb(1'b0, `SASX_REG_STATUS, 32'h0);
        chk(rd, st, "flags after sub");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst      = 1'b1;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0;
        wdt_tick = 1'b0;
        errors   = 0;
        n_tests  = 0;
        cycles   = 0;
        exp_pdto = 2'b00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({31'h0, osc_run}, 32'h1, "osc after reset");
        chk({31'h0, sleeping}, 32'h0, "sleep after reset");
        apb(1'b0, `SASX_REG_STATUS, 32'h0);
        chk(rd, 32'h0, "status reset");
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped read");
        sub_case(8'h03, 8'h02, 1'b1, 5'd5);
        sub_case(8'h02, 8'h02, 1'b1, 5'd31);
        sub_case(8'h01, 8'h02, 1'b1, 5'd0);
        sub_case(8'h50, 8'h0F, 1'b0, 5'd7);
        sub_case(8'h0F, 8'h10, 1'b0, 5'd12);
        // Leave the prescaler mid-count before power-down
        tick(265);
        @(negedge clk);
        chk({24'h0, watchdog_counter}, 32'h1, "wdt before sleep");
        apb(1'b1, `SASX_REG_STATUS, 32'h08);
        apb(1'b1, `SASX_REG_INSTR, {18'h0, `SASX_OP_SLEEP});
        @(negedge clk);
        @(negedge clk);
        chk({31'h0, sleeping}, 32'h1, "sleeping");
        chk({31'h0, osc_run}, 32'h0, "osc stopped");
        chk({24'h0, watchdog_counter}, 32'h0, "wdt cleared");
        apb(1'b0, `SASX_REG_STATUS, 32'h0);
        chk(rd, 32'h30, "status after sleep");
        apb(1'b1, `SASX_REG_INSTR, {18'h0, `SASX_SUB_MATCH | 14'h000C});
        chk({31'h0, err}, 32'h1, "instr while asleep");
        apb(1'b1, `SASX_REG_WAKE, 32'h1);
        @(negedge clk);
        chk({31'h0, sleeping}, 32'h0, "awake");
        chk({31'h0, osc_run}, 32'h1, "osc running");
        apb(1'b0, `SASX_REG_WREG, 32'h0);
        chk(rd, 32'hFF, "w untouched in sleep");
        // Prescaler must restart from zero
        tick(255);
        @(negedge clk);
        chk({24'h0, watchdog_counter}, 32'h0, "prescaler cleared");
        tick(1);
        @(negedge clk);
        chk({24'h0, watchdog_counter}, 32'h1, "prescaler wrap");
        // Subtract after wake keeps the flags left by power-down
        exp_pdto = 2'b10;
        sub_case(8'h80, 8'h01, 1'b1, 5'd20);
        results();
    end
endmodule
